// ==== pkg/serial_pkg.sv ====
package serial_pkg;
	// clock and bit timing
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD_BPS = 115_200;
	localparam int BIT_CLKS = CLK_HZ / BAUD_BPS;
	localparam int DATA_BITS = 8;
	// register byte offsets
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] TXH_OFS = 8'h0C;
	localparam logic [7:0] RXH_OFS = 8'h10;
	localparam logic [7:0] IRQS_OFS = 8'h14;
	localparam logic [7:0] IRQM_OFS = 8'h18;
	// mode register fields
	localparam int MODE_PAR_EN = 0;
	localparam int MODE_PAR_ODD = 1;
	localparam int MODE_MULTIPROC = 2;
	// control register fields
	localparam int CTRL_TX_IRQ_EN = 7;
	localparam int CTRL_RX_IRQ_EN = 6;
	localparam int CTRL_TX_ON = 5;
	localparam int CTRL_RX_ON = 4;
	localparam int CTRL_ADDR_WAIT = 3;
	localparam int CTRL_DONE_IRQ_EN = 2;
	// status register fields, flags except rx address cleared by writing zero
	localparam int ST_TX_EMPTY = 7;
	localparam int ST_RX_FULL = 6;
	localparam int ST_OVERRUN = 5;
	localparam int ST_FRAMING = 4;
	localparam int ST_PARITY = 3;
	localparam int ST_TX_DONE = 2;
	localparam int ST_RX_ADDR = 1;
	localparam int ST_TX_ADDR = 0;
	// interrupt status and mask fields
	localparam int IRQ_TX_EMPTY = 0;
	localparam int IRQ_TX_DONE = 1;
	localparam int IRQ_RX_FULL = 2;
	localparam int IRQ_RX_ERR = 3;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	// line state machine, gray from idle through start, data and extra to stop
	typedef enum logic [2:0] {
		LN_IDLE = 3'h0,
		LN_START = 3'h1,
		LN_DATA = 3'h3,
		LN_EXTRA = 3'h2,
		LN_STOP = 3'h6
	} line_state_t;
endpackage : serial_pkg

// ==== rtl/async_serial_txrx_control.sv ====
`timescale 1ns/1ns
`default_nettype none
module async_serial_txrx_control
	import serial_pkg::*;
#(
	parameter int BIT_CYCLES = BIT_CLKS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// serial line
	input wire logic rxd_i,
	output logic txd_o,
	// interrupt
	output logic irq_o
);
	localparam int CW = 16;

	function automatic logic par_bit(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction : par_bit

	logic [7:0] mode_reg, serial_control_reg, tx_holding_reg, rx_holding_reg;
	logic [7:0] tx_shift_reg, rx_shift_reg;
	logic [3:0] irq_stat, irq_mask;
	logic tx_empty_flag, rx_full_flag, overrun_flag, framing_err_flag, parity_err_flag;
	logic tx_done_flag, rx_addr_flag, tx_addr_bit, tx_next_extra, tx_extra, tx_pending;
	logic rx_extra;
	line_state_t tx_state, rx_state;
	logic [2:0] tx_bit, rx_bit;
	logic [31:0] next_dat;

	// bus decode
	wire req = cyc_i && stb_i && !ack_o;
	wire wr = cyc_i && stb_i && ack_o && we_i && sel_i[0]; // write lands on the ack edge
	wire wr_mode = wr && adr_i == MODE_OFS;
	wire wr_ctrl = wr && adr_i == CTRL_OFS;
	wire wr_stat = wr && adr_i == STAT_OFS;
	wire wr_txh = wr && adr_i == TXH_OFS;
	wire wr_irqs = wr && adr_i == IRQS_OFS;
	wire wr_irqm = wr && adr_i == IRQM_OFS;

	// control and mode fields
	wire tx_on = serial_control_reg[CTRL_TX_ON];
	wire rx_on = serial_control_reg[CTRL_RX_ON];
	wire addr_wait_en = serial_control_reg[CTRL_ADDR_WAIT];
	wire multiproc_mode = mode_reg[MODE_MULTIPROC];
	wire par_en = mode_reg[MODE_PAR_EN] && !multiproc_mode;
	wire has_extra = par_en || multiproc_mode;
	wire addr_wait = addr_wait_en && multiproc_mode;

	// transmit sequencing strobes
	wire tx_tick;
	wire tx_load_idle = tx_state == LN_IDLE && tx_on && !tx_empty_flag;
	wire tx_to_stop = tx_tick && ((tx_state == LN_DATA && tx_bit == 3'(DATA_BITS - 1) &&
		!has_extra) || tx_state == LN_EXTRA);
	wire tx_load_b2b = tx_to_stop && tx_on && !tx_empty_flag;
	wire tx_load = tx_load_idle || tx_load_b2b;
	wire tx_done_set = tx_to_stop && tx_empty_flag;

	// receive sequencing strobes
	wire rx_tick;
	wire rx_begin = rx_state == LN_IDLE && rx_on && !rxd_i;
	wire rx_end = rx_tick && rx_state == LN_STOP;
	wire rx_skip = addr_wait && !rx_extra;
	wire rx_take = rx_end && !rx_skip;
	wire rx_addr_hit = rx_end && addr_wait && rx_extra;
	wire rx_ovr = rx_take && rx_full_flag;
	wire rx_frm = rx_take && !rxd_i;
	wire rx_par = rx_take && par_en && (rx_extra != par_bit(rx_shift_reg,
		mode_reg[MODE_PAR_ODD]));

	// interrupt events
	wire [3:0] irq_ev = {(rx_ovr || rx_frm || rx_par) && serial_control_reg[CTRL_RX_IRQ_EN],
		rx_take && !rx_full_flag && serial_control_reg[CTRL_RX_IRQ_EN],
		tx_done_set && serial_control_reg[CTRL_DONE_IRQ_EN],
		tx_load && serial_control_reg[CTRL_TX_IRQ_EN]};

	bit_timer #(.DIV(BIT_CYCLES), .W(CW)) u_tx_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(tx_state == LN_IDLE || !tx_on),
		.load_i(CW'(BIT_CYCLES - 1)),
		.tick_o(tx_tick)
	);

	bit_timer #(.DIV(BIT_CYCLES), .W(CW)) u_rx_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(rx_state == LN_IDLE || !rx_on),
		.load_i(CW'(BIT_CYCLES / 2 - 1)),
		.tick_o(rx_tick)
	);

	// transmit line, mark when idle
	always_comb begin
		case (tx_state)
			LN_START: txd_o = 1'b0;
			LN_DATA: txd_o = tx_shift_reg[0];
			LN_EXTRA: txd_o = tx_extra;
			default: txd_o = 1'b1;
		endcase
	end

	// transmit frame machine
	always_ff @(posedge clk_i) begin
		if (rst_i || !tx_on) begin
			tx_state <= LN_IDLE;
			tx_bit <= 3'h0;
			tx_pending <= 1'b0;
		end else begin
			case (tx_state)
				LN_IDLE: if (tx_load_idle) tx_state <= LN_START;
				LN_START: if (tx_tick) tx_state <= LN_DATA;
				LN_DATA: if (tx_tick) begin
					tx_bit <= tx_bit + 3'h1;
					if (tx_bit == 3'(DATA_BITS - 1)) tx_state <= has_extra ? LN_EXTRA : LN_STOP;
				end
				LN_EXTRA: if (tx_tick) tx_state <= LN_STOP;
				LN_STOP: if (tx_tick) tx_state <= tx_pending ? LN_START : LN_IDLE;
				default: tx_state <= LN_IDLE;
			endcase
			if (tx_to_stop) tx_pending <= tx_load_b2b;
		end
	end

	// shift register load and shifting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_shift_reg <= 8'hFF;
			tx_extra <= 1'b1;
			tx_next_extra <= 1'b1;
		end else if (tx_load_idle) begin
			tx_shift_reg <= tx_holding_reg;
			tx_extra <= multiproc_mode ? tx_addr_bit :
				par_bit(tx_holding_reg, mode_reg[MODE_PAR_ODD]);
		end else if (tx_load_b2b) begin
			tx_next_extra <= multiproc_mode ? tx_addr_bit :
				par_bit(tx_holding_reg, mode_reg[MODE_PAR_ODD]);
			tx_shift_reg <= tx_holding_reg;
		end else if (tx_state == LN_STOP && tx_tick) begin
			tx_extra <= tx_next_extra;
		end else if (tx_state == LN_DATA && tx_tick) begin
			tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
		end
	end

	// receive frame machine
	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_on) begin
			rx_state <= LN_IDLE;
			rx_bit <= 3'h0;
		end else begin
			case (rx_state)
				LN_IDLE: if (rx_begin) rx_state <= LN_START;
				LN_START: if (rx_tick) rx_state <= rxd_i ? LN_IDLE : LN_DATA;
				LN_DATA: if (rx_tick) begin
					rx_bit <= rx_bit + 3'h1;
					if (rx_bit == 3'(DATA_BITS - 1)) rx_state <= has_extra ? LN_EXTRA : LN_STOP;
				end
				LN_EXTRA: if (rx_tick) rx_state <= LN_STOP;
				LN_STOP: if (rx_tick) rx_state <= LN_IDLE;
				default: rx_state <= LN_IDLE;
			endcase
		end
	end

	// receive shift and holding registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_shift_reg <= 8'h00;
			rx_extra <= 1'b0;
			rx_holding_reg <= 8'h00;
		end else begin
			if (rx_state == LN_DATA && rx_tick) rx_shift_reg <= {rxd_i, rx_shift_reg[7:1]};
			if (rx_state == LN_START) rx_extra <= 1'b0;
			else if (rx_state == LN_EXTRA && rx_tick) rx_extra <= rxd_i;
			if (rx_take && !rx_full_flag) rx_holding_reg <= rx_shift_reg;
		end
	end

	// status flags, hardware set wins over software clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_empty_flag <= 1'b1;
			{rx_full_flag, overrun_flag, framing_err_flag, parity_err_flag} <= 4'h0;
			{tx_done_flag, rx_addr_flag, tx_addr_bit} <= 3'b100;
		end else begin
			tx_empty_flag <= !tx_on || tx_load ||
				(tx_empty_flag && !(wr_stat && !dat_i[ST_TX_EMPTY]));
			rx_full_flag <= (rx_take && !rx_full_flag) ||
				(rx_full_flag && !(wr_stat && !dat_i[ST_RX_FULL]));
			overrun_flag <= rx_ovr || (overrun_flag && !(wr_stat && !dat_i[ST_OVERRUN]));
			framing_err_flag <= rx_frm ||
				(framing_err_flag && !(wr_stat && !dat_i[ST_FRAMING]));
			parity_err_flag <= rx_par ||
				(parity_err_flag && !(wr_stat && !dat_i[ST_PARITY]));
			tx_done_flag <= tx_done_set || (tx_done_flag && !tx_load &&
				!(wr_stat && !dat_i[ST_TX_DONE]));
			rx_addr_flag <= rx_addr_hit || (rx_take ? rx_extra : rx_addr_flag);
			if (wr_stat) tx_addr_bit <= dat_i[ST_TX_ADDR];
		end
	end

	// control, mode and holding registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_control_reg <= CTRL_RST;
			mode_reg <= MODE_RST;
			tx_holding_reg <= 8'h00;
			irq_mask <= 4'h0;
		end else begin
			if (wr_ctrl) serial_control_reg <= dat_i[7:0];
			else if (rx_addr_hit) serial_control_reg[CTRL_ADDR_WAIT] <= 1'b0;
			if (wr_mode) mode_reg <= dat_i[7:0];
			if (wr_txh) tx_holding_reg <= dat_i[7:0];
			if (wr_irqm) irq_mask <= dat_i[3:0];
		end
	end

	// sticky interrupt bits, write one to clear
	always_ff @(posedge clk_i) begin
		if (rst_i) irq_stat <= 4'h0;
		else irq_stat <= irq_ev | (irq_stat & ~(wr_irqs ? dat_i[3:0] : 4'h0));
	end
	assign irq_o = |(irq_stat & irq_mask);

	// read mux, unmapped reads return zero
	always_comb begin
		case (adr_i)
			MODE_OFS: next_dat = {24'h0, mode_reg};
			CTRL_OFS: next_dat = {24'h0, serial_control_reg};
			STAT_OFS: next_dat = {24'h0, tx_empty_flag, rx_full_flag, overrun_flag,
				framing_err_flag, parity_err_flag, tx_done_flag, rx_addr_flag, tx_addr_bit};
			TXH_OFS: next_dat = {24'h0, tx_holding_reg};
			RXH_OFS: next_dat = {24'h0, rx_holding_reg};
			IRQS_OFS: next_dat = {28'h0, irq_stat};
			IRQM_OFS: next_dat = {28'h0, irq_mask};
			default: next_dat = 32'h0;
		endcase
	end

	// one-wait-state acknowledge with registered data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= req;
			if (req && !we_i) dat_o <= next_dat;
		end
	end

	// checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_stop_begin;
		tx_to_stop && tx_on;
	endsequence
	sequence s_stop_sent;
		tx_state == LN_STOP && txd_o;
	endsequence

	property p_tx_off_empty;
		!tx_on |=> tx_empty_flag && tx_state == LN_IDLE && txd_o;
	endproperty
	a_tx_off_empty: assert property (p_tx_off_empty) else $error("tx off not idle");

	property p_tx_start;
		tx_load_idle |=> tx_state == LN_START && tx_empty_flag && !txd_o;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("send did not start");

	property p_idle_mark;
		tx_state == LN_IDLE |-> txd_o;
	endproperty
	a_idle_mark: assert property (p_idle_mark) else $error("idle line not high");

	property p_done_at_stop;
		s_stop_begin ##0 tx_empty_flag |=> tx_done_flag && tx_state == LN_STOP && txd_o;
	endproperty
	a_done_at_stop: assert property (p_done_at_stop) else $error("done flag missed");

	property p_back_to_back;
		s_stop_begin ##0 !tx_empty_flag |=> tx_empty_flag && tx_pending ##0 s_stop_sent;
	endproperty
	a_back_to_back: assert property (p_back_to_back) else $error("next frame not queued");

	property p_done_irq;
		tx_done_set && serial_control_reg[CTRL_DONE_IRQ_EN] |=> irq_stat[IRQ_TX_DONE];
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("done irq missing");

	property p_rx_off_hold;
		!rx_on && !wr_stat |=> $stable(rx_full_flag) && $stable(overrun_flag) &&
			$stable(framing_err_flag) && $stable(parity_err_flag);
	endproperty
	a_rx_off_hold: assert property (p_rx_off_hold) else $error("rx flags moved");

	property p_skip_frame;
		rx_end && addr_wait && !rx_extra && !wr_stat |=> $stable(rx_holding_reg) &&
			$stable(rx_full_flag) && $stable(overrun_flag) && $stable(framing_err_flag);
	endproperty
	a_skip_frame: assert property (p_skip_frame) else $error("skipped frame stored");

	property p_addr_hit;
		rx_addr_hit && !wr_ctrl |=> rx_addr_flag && !addr_wait_en;
	endproperty
	a_addr_hit: assert property (p_addr_hit) else $error("address wait not ended");

	property p_wait_needs_mp;
		rx_end && !multiproc_mode && !rx_full_flag |=> rx_full_flag;
	endproperty
	a_wait_needs_mp: assert property (p_wait_needs_mp) else $error("frame dropped");
endmodule : async_serial_txrx_control
`default_nettype wire

// ==== rtl/bit_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module bit_timer #(
	parameter int DIV = 217,
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic restart_i,
	input wire logic [W-1:0] load_i,
	// one-cycle tick at count zero
	output logic tick_o
);
	logic [W-1:0] cnt;

	assign tick_o = (cnt == '0) && !restart_i;

	// count down, reload a full bit after each tick
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			cnt <= rst_i ? W'(DIV - 1) : load_i;
		end else if (cnt == '0) begin
			cnt <= W'(DIV - 1);
		end else begin
			cnt <= cnt - 1'b1;
		end
	end
endmodule : bit_timer
`default_nettype wire

// ==== verif/serial_station.sv ====
`timescale 1ns/1ns
`default_nettype none
module serial_station #(
	parameter int BIT = 8
) (
	// clock
	input wire logic clk_i,
	// serial lines and format
	input wire logic txd_i,
	input wire logic extra_i,
	output logic rxd_o
);
	int cyc = 0;
	int starts[$];
	logic [9:0] frames[$];
	logic [9:0] f;
	// free cycle count for frame spacing
	always @(posedge clk_i) cyc <= cyc + 1;
	// sample each frame mid-bit: data lsb first, extra bit, stop
	initial begin
		rxd_o = 1'b1;
		forever begin
			@(negedge txd_i);
			starts.push_back(cyc);
			repeat (BIT / 2) @(posedge clk_i);
			f = 10'h000;
			for (int i = 0; i < 10; i++) begin
				if (i == 8 && !extra_i) continue;
				repeat (BIT) @(posedge clk_i);
				f[i] = txd_i;
			end
			frames.push_back(f);
		end
	end
	// drive one frame on the receive line, idle high after
	task automatic send_frame(input logic [7:0] d, input logic x, input logic stop);
		logic [9:0] b;
		b = {stop, x, d};
		@(posedge clk_i);
		rxd_o <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			if (i == 8 && !extra_i) continue;
			repeat (BIT) @(posedge clk_i);
			rxd_o <= b[i];
		end
		repeat (BIT) @(posedge clk_i);
		rxd_o <= 1'b1;
		// one idle bit so a low stop cannot merge into the next start
		repeat (BIT) @(posedge clk_i);
	endtask : send_frame
endmodule : serial_station
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import serial_pkg::*;
	localparam int BIT = 8;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ext;
	logic [7:0] adr_i, q, a, b, c;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic ack_o, rxd_i, txd_o, irq_o;
	int mismatches = 0;
	int comparisons = 0;
	logic [7:0] modes[4] = '{8'h01, 8'h03, 8'h04, 8'h04};
	logic [7:0] stw[4] = '{8'h7F, 8'h7F, 8'h7E, 8'h7F};
	async_serial_txrx_control #(.BIT_CYCLES(BIT)) async_serial_txrx_control_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));
	serial_station #(.BIT(BIT)) serial_station_inst (
		.clk_i(clk_i), .txd_i(txd_o), .extra_i(ext), .rxd_o(rxd_i));
	// closing verdict
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// one classic wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			test_done();
		end
		// let the write settle before outputs are looked at
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [7:0] ad, input string nm, input logic [7:0] exp);
		wb(1'b0, ad, 8'h00);
		check(nm, {24'h000000, q}, {24'h000000, exp});
	endtask : rd
	// bounded wait for the station to hold k frames
	task automatic wait_frames(input int k);
		int n;
		for (n = 0; n < 4000 && serial_station_inst.frames.size() < k; n++) @(posedge clk_i);
		if (n >= 4000) begin
			mismatches++;
			test_done();
		end
	endtask : wait_frames
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, ext} = 4'h0;
		adr_i = 8'h00;
		sel_i = 4'hF;
		dat_i = 32'h00000000;
		void'($urandom(32'hA88D));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values and unmapped place
		rd(CTRL_OFS, "ctrl", CTRL_RST);
		rd(MODE_OFS, "mode", MODE_RST);
		rd(STAT_OFS, "status", 8'h84);
		rd(8'h1C, "unmapped", 8'h00);
		check("txd idle", txd_o, 1'b1);
		$display("test reset done");
		// transmitter off: empty flag stays set
		wb(1'b1, TXH_OFS, 8'h5A);
		wb(1'b1, STAT_OFS, 8'h7F);
		rd(STAT_OFS, "status off", 8'h85);
		check("txd off", txd_o, 1'b1);
		$display("test tx off done");
		// back-to-back frames, empty and done interrupts
		a = 8'($urandom);
		b = 8'($urandom);
		wb(1'b1, IRQM_OFS, 8'h03);
		wb(1'b1, CTRL_OFS, 8'hA4);
		wb(1'b1, TXH_OFS, a);
		wb(1'b1, STAT_OFS, 8'h7F);
		wb(1'b1, TXH_OFS, b);
		wb(1'b1, STAT_OFS, 8'h7F);
		wait_frames(2);
		check("frame a", serial_station_inst.frames[0], {2'b10, a});
		check("frame b", serial_station_inst.frames[1], {2'b10, b});
		check("gap", serial_station_inst.starts[1] - serial_station_inst.starts[0], 10 * BIT);
		repeat (BIT) @(posedge clk_i);
		rd(STAT_OFS, "status done", 8'h85);
		rd(IRQS_OFS, "irq status", 8'h03);
		check("irq on", irq_o, 1'b1);
		wb(1'b1, IRQM_OFS, 8'h00);
		check("irq masked", irq_o, 1'b0);
		wb(1'b1, IRQM_OFS, 8'h03);
		wb(1'b1, IRQS_OFS, 8'h03);
		check("irq cleared", irq_o, 1'b0);
		check("txd mark", txd_o, 1'b1);
		$display("test tx stream done");
		// parity and address-flag formats
		for (int i = 0; i < 4; i++) begin
			c = 8'($urandom);
			wb(1'b1, CTRL_OFS, 8'h00);
			wb(1'b1, MODE_OFS, modes[i]);
			ext <= 1'b1;
			wb(1'b1, CTRL_OFS, 8'h20);
			wb(1'b1, TXH_OFS, c);
			wb(1'b1, STAT_OFS, stw[i]);
			wait_frames(3 + i);
			check("frame fmt", serial_station_inst.frames[2 + i], {1'b1,
				(i == 0) ? ^c : (i == 1) ? ~^c : stw[i][0], c});
		end
		$display("test formats done");
		// receive with framing error, overrun, then disable
		wb(1'b1, CTRL_OFS, 8'h00);
		wb(1'b1, MODE_OFS, 8'h00);
		ext <= 1'b0;
		wb(1'b1, CTRL_OFS, 8'h10);
		a = 8'($urandom);
		serial_station_inst.send_frame(a, 1'b0, 1'b0);
		serial_station_inst.send_frame(~a, 1'b0, 1'b1);
		wb(1'b1, CTRL_OFS, 8'h00);
		serial_station_inst.send_frame(8'h33, 1'b0, 1'b1);
		wb(1'b0, STAT_OFS, 8'h00);
		check("rx flags", q & 8'h70, 8'h70);
		rd(RXH_OFS, "rx data", a);
		wb(1'b1, STAT_OFS, 8'h8F);
		$display("test rx done");
		// address wait drops flag-zero frames
		wb(1'b1, MODE_OFS, 8'h04);
		ext <= 1'b1;
		wb(1'b1, CTRL_OFS, 8'h18);
		serial_station_inst.send_frame(8'hC3, 1'b0, 1'b1);
		wb(1'b0, STAT_OFS, 8'h00);
		check("skip flags", q & 8'h72, 8'h00);
		rd(RXH_OFS, "skip data", a);
		serial_station_inst.send_frame(b, 1'b1, 1'b1);
		wb(1'b0, STAT_OFS, 8'h00);
		check("addr flags", q & 8'h72, 8'h42);
		rd(RXH_OFS, "addr data", b);
		rd(CTRL_OFS, "wait cleared", 8'h10);
		$display("test address wait done");
		// receive parity error raises full and error interrupts
		wb(1'b1, STAT_OFS, 8'h8F);
		wb(1'b1, CTRL_OFS, 8'h00);
		wb(1'b1, MODE_OFS, 8'h01);
		wb(1'b1, IRQM_OFS, 8'h0C);
		wb(1'b1, CTRL_OFS, 8'h50);
		c = 8'($urandom);
		serial_station_inst.send_frame(c, ~^c, 1'b1);
		wb(1'b0, STAT_OFS, 8'h00);
		check("parity flags", q & 8'h78, 8'h48);
		rd(RXH_OFS, "parity data", c);
		rd(IRQS_OFS, "rx irq status", 8'h0C);
		check("rx irq on", irq_o, 1'b1);
		$display("test parity done");
		test_done();
	end
endmodule : testbench
`default_nettype wire
